/* File: src/qbtp_transceiver.sv */
// Quad bus transceiver with parity behind an APB slave
`timescale 1ns/1ns
`include "qbtp_params.svh"

// Overview of operation
// - Four stored bits fed by shared-pick muxes
// - Pick low loads word A, high word B
// - Driver register loads only on clock rise
// - Drive inhibit high releases all bus lines
// - Enabled lines carry inverted driver bits
// - Lines resolve wired: any pull wins low
// - Receiver inverts lines, restoring original polarity
// - Hold low: receiver follows inverted lines
// - Hold high: receiver keeps captured word
// - Receiver sees the resolved line incl. own
// - Driving: parity generated over selected word
// - Inhibited: parity checks receiver latch bits
module qbtp_transceiver
    import qbtp_pkg::*;
#(
    parameter int ADDR_W = 8                // APB address width
)
(
    input  wire logic              pclk,                  // System clock
    input  wire logic              presetn,               // Async reset
    input  wire logic              ce,                    // Clock enable
    input  wire logic              psel,                  // APB select
    input  wire logic              penable,               // APB enable
    input  wire logic              pwrite,                // APB write
    input  wire logic [ADDR_W-1:0] paddr,                 // APB address
    input  wire logic [31:0]       pwdata,                // APB wdata
    output logic      [31:0]       prdata,                // APB rdata
    output logic                   pready,                // APB ready
    output logic                   pslverr,               // APB error
    input  wire logic              driver_register_clock, // Load pin
    input  wire logic [3:0]        bus_level,             // Line levels
    output qbtp_bus_drv_type       bus_drv,               // Line drive
    output logic      [3:0]        rx_word,               // Receiver
    output logic                   parity_out             // Odd parity
);

    // ==========================================================
    // Elaboration checks
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 8 and 32");
    end

    localparam qbtp_state_type ST_RST = '{
        ctrl    : qbtp_ctrl_type'(`QBTP_CTRL_RST),
        a_word  : `QBTP_WORD_RST,
        b_word  : `QBTP_WORD_RST,
        drv     : `QBTP_WORD_RST,
        rx      : `QBTP_WORD_RST,
        default : '0
    };

    qbtp_state_type          st_r;
    qbtp_state_type          st_nxt;
    logic [`QBTP_SYNC_W-1:0] pins_s;
    logic [3:0]              bus_s;
    logic                    clk_s;
    logic [3:0]              sel_word;
    logic                    load_rise;
    logic                    access;
    logic [ADDR_W-1:0]       addr_hi;
    logic                    addr_ok;
    logic [7:0]              addr_lo;

    // ==========================================================
    // Pin synchronisers; lines pass inverted so a cleared stage
    // reads as released high lines and no false word follows reset
    qbtp_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({driver_register_clock, ~bus_level}),
        .q       (pins_s)
    );

    assign clk_s   = pins_s[4];
    assign bus_s   = ~pins_s[3:0];
    assign addr_hi = paddr >> 8;
    assign addr_ok = (addr_hi == '0);
    assign addr_lo = paddr[7:0];
    assign access  = psel && penable;

    // ==========================================================
    // Next-state logic
    always_comb begin
        st_nxt    = st_r;
        // One pick steers all four bit muxes
        sel_word  = st_r.ctrl.word_pick ? st_r.b_word
                                        : st_r.a_word;
        load_rise = clk_s && !st_r.clk_prev;
        st_nxt.clk_prev = clk_s;

        // Driver register
        if (load_rise) begin
            st_nxt.drv = sel_word;
        end

        // Open-collector drive: output level is always low
        st_nxt.bus.o = 4'h0;
        if (st_r.ctrl.drive_inhibit) begin
            st_nxt.bus.oe = 4'h0;
        end else begin
            st_nxt.bus.oe = st_r.drv;
        end

        // Receiver latch reads the resolved line
        if (!st_r.ctrl.receive_latch_hold) begin
            st_nxt.rx = ~bus_s;
        end

        // Parity generate or check
        if (st_r.ctrl.drive_inhibit) begin
            st_nxt.parity = ~^st_r.rx;
        end else begin
            st_nxt.parity = ~^sel_word;
        end

        // APB slave: one wait cycle, then completion
        if (access && !st_r.pready) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = 32'h0000_0000;
            if (!addr_ok) begin
                st_nxt.pslverr = 1'b1;
            end else if (addr_lo == `QBTP_OFF_CTRL) begin
                st_nxt.prdata[2:0] = st_r.ctrl;
            end else if (addr_lo == `QBTP_OFF_AWORD) begin
                st_nxt.prdata[3:0] = st_r.a_word;
            end else if (addr_lo == `QBTP_OFF_BWORD) begin
                st_nxt.prdata[3:0] = st_r.b_word;
            end else if (addr_lo == `QBTP_OFF_DRIVER) begin
                st_nxt.prdata[3:0] = st_r.drv;
                st_nxt.pslverr     = pwrite;
            end else if (addr_lo == `QBTP_OFF_RECV) begin
                st_nxt.prdata[3:0] = st_r.rx;
                st_nxt.pslverr     = pwrite;
            end else if (addr_lo == `QBTP_OFF_STATUS) begin
                st_nxt.prdata[`QBTP_STAT_PARITY_BIT]  = st_r.parity;
                st_nxt.prdata[`QBTP_STAT_DRIVING_BIT] = |st_r.bus.oe;
                st_nxt.pslverr = pwrite;
            end else begin
                st_nxt.pslverr = 1'b1;
            end
            if (pwrite) begin
                st_nxt.prdata = 32'h0000_0000;
            end
        end else if (access && st_r.pready) begin
            st_nxt.pready = 1'b0;
            if (pwrite && !st_r.pslverr) begin
                if (addr_lo == `QBTP_OFF_CTRL) begin
                    st_nxt.ctrl = qbtp_ctrl_type'(pwdata[2:0]);
                end else if (addr_lo == `QBTP_OFF_AWORD) begin
                    st_nxt.a_word = pwdata[3:0];
                end else if (addr_lo == `QBTP_OFF_BWORD) begin
                    st_nxt.b_word = pwdata[3:0];
                end
            end
        end else begin
            st_nxt.pready  = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
    end

    // ==========================================================
    // State register: frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign prdata     = st_r.prdata;
    assign pready     = st_r.pready;
    assign pslverr    = st_r.pslverr;
    assign bus_drv    = st_r.bus;
    assign rx_word    = st_r.rx;
    assign parity_out = st_r.parity;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_load_on_rise: assert property (
        ce && load_rise |=> st_r.drv == $past(sel_word))
    else $error("driver register did not load the picked word");

    a_load_steady: assert property (
        ce && !load_rise |=> $stable(st_r.drv))
    else $error("driver register changed without a clock rise");

    a_drive_released: assert property (
        ce && st_r.ctrl.drive_inhibit |=> bus_drv.oe == 4'h0)
    else $error("bus driven while drive inhibit is high");

    a_drive_inverted: assert property (
        ce && !st_r.ctrl.drive_inhibit |=> bus_drv.oe == $past(st_r.drv))
    else $error("bus pull does not match driver register");

    a_open_collector: assert property (
        bus_drv.o == 4'h0)
    else $error("bus output level is not low");

    a_rx_follow: assert property (
        ce && !st_r.ctrl.receive_latch_hold |=> rx_word == ~$past(bus_s))
    else $error("receiver does not follow inverted bus");

    a_rx_hold: assert property (
        ce && st_r.ctrl.receive_latch_hold |=> $stable(rx_word))
    else $error("receiver latch changed while held");

    a_parity_gen: assert property (
        ce && !st_r.ctrl.drive_inhibit |=> parity_out == ~^$past(sel_word))
    else $error("generated parity wrong");

    a_parity_chk: assert property (
        ce && st_r.ctrl.drive_inhibit |=> parity_out == ~^$past(st_r.rx))
    else $error("checked parity wrong");

    a_apb_answer: assert property (
        ce && access && !pready |=> pready ##1 (!pready || !ce))
    else $error("APB answer not exactly one cycle long");

endmodule

/* File: inc/qbtp_params.svh */
// Register offsets, field positions and reset values of the transceiver
`ifndef QBTP_PARAMS_SVH
`define QBTP_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define QBTP_OFF_CTRL    8'h00
`define QBTP_OFF_AWORD   8'h04
`define QBTP_OFF_BWORD   8'h08
`define QBTP_OFF_DRIVER  8'h0C
`define QBTP_OFF_RECV    8'h10
`define QBTP_OFF_STATUS  8'h14

// ==========================================================
// Field positions
`define QBTP_CTRL_PICK_BIT     0
`define QBTP_CTRL_INHIBIT_BIT  1
`define QBTP_CTRL_HOLD_BIT     2
`define QBTP_STAT_PARITY_BIT   0
`define QBTP_STAT_DRIVING_BIT  1

// ==========================================================
// Reset values
`define QBTP_CTRL_RST    3'h2
`define QBTP_WORD_RST    4'h0

// ==========================================================
// Widths
`define QBTP_WORD_W      4
`define QBTP_SYNC_W      5

`endif

/* File: inc/qbtp_pkg.sv */
// Types shared by the transceiver design files
package qbtp_pkg;

    // ==========================================================
    // Control bits written by software
    typedef struct packed {
        logic receive_latch_hold;
        logic drive_inhibit;
        logic word_pick;
    } qbtp_ctrl_type;

    // ==========================================================
    // Open-collector bus pins: oe high pulls the line low
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] o;
    } qbtp_bus_drv_type;

    // ==========================================================
    // Two-stage synchroniser state
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] stable;
    } qbtp_sync_type;

    // ==========================================================
    // Whole state of the transceiver except the pin synchroniser stages
    typedef struct packed {
        qbtp_ctrl_type    ctrl;
        logic [3:0]       a_word;
        logic [3:0]       b_word;
        logic [3:0]       drv;
        logic [3:0]       rx;
        logic             clk_prev;
        logic             parity;
        qbtp_bus_drv_type bus;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } qbtp_state_type;

endpackage

/* File: src/qbtp_sync.sv */
// Two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ns
`include "qbtp_params.svh"

module qbtp_sync
    import qbtp_pkg::*;
(
    input  wire logic                    pclk,    // System clock
    input  wire logic                    presetn, // Async reset, low
    input  wire logic                    ce,      // Clock enable
    input  wire logic [`QBTP_SYNC_W-1:0] d,       // Asynchronous inputs
    output logic      [`QBTP_SYNC_W-1:0] q        // Synchronised inputs
);

    qbtp_sync_type st_r;
    qbtp_sync_type st_nxt;

    // ==========================================================
    // Stage chain: the first stage feeds only the second
    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta   = d;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.stable;

endmodule

/* File: tb/qbtp_bus_agent.sv */
// Other agents on the shared open-collector bus, with pull-up
`timescale 1ns/1ns

module qbtp_bus_agent
    import qbtp_pkg::*;
(
    input  wire qbtp_bus_drv_type dev,  // Drive from the transceiver
    input  wire logic [3:0]       pull, // Lines pulled by other agents
    output logic      [3:0]       line  // Resolved line levels
);
    // ==========================================================
    // Wired resolution: any pull wins, released lines float high
    assign line = ~((dev.oe & ~dev.o) | pull);
endmodule

/* File: tb/tb_quad_bus_transceiver_parity.sv */
// Self-checking bench for the quad bus transceiver
`timescale 1ns/1ns
`include "qbtp_params.svh"

module tb_quad_bus_transceiver_parity
    import qbtp_pkg::*;
;
    typedef struct packed {
        logic       pick;
        logic [3:0] a;
        logic [3:0] b;
        logic [3:0] drv;
        logic       par;
    } qbtp_row_type;

    logic             pclk, presetn, ce, psel, penable, pwrite, drc;
    logic             pready, pslverr, parity_out, err;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [3:0]       bus_level, rx_word, pull;
    qbtp_bus_drv_type bus_drv;
    int               fails, n_compared;
    qbtp_row_type     rows [5] = '{
        '{1'h0, 4'h5, 4'hA, 4'h5, 1'h1},
        '{1'h1, 4'h5, 4'hE, 4'hE, 1'h0},
        '{1'h0, 4'hF, 4'h0, 4'hF, 1'h1},
        '{1'h0, 4'h0, 4'hF, 4'h0, 1'h1},
        '{1'h1, 4'h0, 4'h1, 4'h1, 1'h0}};

    qbtp_transceiver i_qbtp_transceiver (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .driver_register_clock(drc),
        .bus_level(bus_level), .bus_drv(bus_drv), .rx_word(rx_word),
        .parity_out(parity_out));

    qbtp_bus_agent i_qbtp_bus_agent (
        .dev(bus_drv), .pull(pull), .line(bus_level));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ==========================================================
    // Tasks
    task end_of_test;
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("mismatch %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            end_of_test();
        end else begin
            rd      = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task settle;
        repeat (10) @(negedge pclk);
    endtask

    task pulse;
        @(posedge pclk);
        drc <= 1'b1;
        repeat (3) @(posedge pclk);
        drc <= 1'b0;
        settle();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, drc} = 4'h0;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        pull = 4'h0;
        fails = 0;
        n_compared = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("oe_rst", 32'h0, bus_drv.oe);
        apb(1'b0, `QBTP_OFF_CTRL, 32'h0);
        chk("ctrl_rst", `QBTP_CTRL_RST, rd);
        foreach (rows[i]) begin
            apb(1'b1, `QBTP_OFF_AWORD, rows[i].a);
            apb(1'b1, `QBTP_OFF_BWORD, rows[i].b);
            apb(1'b1, `QBTP_OFF_CTRL, rows[i].pick);
            settle();
            chk("par_gen", rows[i].par, parity_out);
            pulse();
            apb(1'b0, `QBTP_OFF_DRIVER, 32'h0);
            chk("drv", rows[i].drv, rd);
            chk("oe", rows[i].drv, bus_drv.oe);
            chk("o", 32'h0, bus_drv.o);
            chk("rx", rows[i].drv, rx_word);
        end
        // Clock held high while the picked word changes
        apb(1'b1, `QBTP_OFF_BWORD, 32'h3);
        settle();
        @(posedge pclk);
        drc <= 1'b1;
        settle();
        apb(1'b1, `QBTP_OFF_BWORD, 32'hC);
        settle();
        @(posedge pclk);
        drc <= 1'b0;
        settle();
        apb(1'b0, `QBTP_OFF_DRIVER, 32'h0);
        chk("drv_steady", 32'h3, rd);
        // Another agent pulls line 3 low as well
        @(posedge pclk);
        pull <= 4'h8;
        settle();
        chk("rx_wired", 32'hB, rx_word);
        // Latch closed, bus changes ignored
        apb(1'b1, `QBTP_OFF_CTRL, 32'h5);
        pull <= 4'h4;
        settle();
        chk("rx_hold", 32'hB, rx_word);
        chk("par_hold", 32'h1, parity_out);
        apb(1'b1, `QBTP_OFF_CTRL, 32'h1);
        settle();
        chk("rx_open", 32'h7, rx_word);
        apb(1'b0, `QBTP_OFF_STATUS, 32'h0);
        chk("status_drv", 32'h3, rd);
        // Drivers released, parity checks the received word
        apb(1'b1, `QBTP_OFF_CTRL, 32'h3);
        pull <= 4'h1;
        settle();
        chk("oe_inh", 32'h0, bus_drv.oe);
        chk("rx_inh", 32'h1, rx_word);
        chk("par_chk", 32'h0, parity_out);
        @(posedge pclk);
        pull <= 4'h6;
        settle();
        chk("par_chk2", 32'h1, parity_out);
        // Clock enable low freezes the whole block
        @(posedge pclk);
        ce <= 1'b0;
        @(posedge pclk);
        pull <= 4'h2;
        settle();
        chk("rx_frozen", 32'h6, rx_word);
        chk("par_frozen", 32'h1, parity_out);
        @(posedge pclk);
        ce <= 1'b1;
        settle();
        chk("par_thaw", 32'h0, parity_out);
        apb(1'b0, `QBTP_OFF_RECV, 32'h0);
        chk("recv_rd", 32'h2, rd);
        apb(1'b0, `QBTP_OFF_STATUS, 32'h0);
        chk("status_inh", 32'h0, rd);
        // Refused accesses
        apb(1'b1, `QBTP_OFF_DRIVER, 32'hF);
        chk("ro_err", 32'h1, err);
        apb(1'b0, 8'h20, 32'h0);
        chk("unm_err", 32'h1, err);
        chk("unm_rd", 32'h0, rd);
        // Reset again in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk("oe_rst2", 32'h0, bus_drv.oe);
        apb(1'b0, `QBTP_OFF_CTRL, 32'h0);
        chk("ctrl_rst2", `QBTP_CTRL_RST, rd);
        apb(1'b0, `QBTP_OFF_DRIVER, 32'h0);
        chk("drv_rst2", `QBTP_WORD_RST, rd);
        end_of_test();
    end
endmodule
